// file: rtl/fsmc_sequencer.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fsmc_sequencer
    import fsmc_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 resetn_in,
    // APB slave
    input  wire fsmc_apb_req_t        apb_req_in,
    output logic [31:0]               prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    // Flash array mass erase and verify
    output logic                      erase_req_out,
    input  wire fsmc_verify_t         verify_in,
    // Configuration and mode inputs
    input  wire logic                 protect_any_in,
    input  wire logic                 unsecure_mode_ok_in,
    input  wire logic                 margin_mode_ok_in,
    input  wire logic [7:0]           security_config_in,
    input  wire logic [KEY_COUNT-1:0][15:0] stored_keys_in,
    // Security, command complete flag and read margin state
    output logic                      secured_out,
    output logic                      command_complete_flag_out,
    output logic [1:0]                pflash_read_margin_out,
    output logic [1:0]                dflash_read_margin_out
);

    fsmc_regs_t               r_q;
    fsmc_regs_t               r_d;
    logic [KEY_COUNT-1:0]     key_eq;

    // Register address match
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
        addr_is = (a == target);
    endfunction

    // Any of the four register words; all else answers with a slave error
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = addr_is(a, ADDR_STATUS) | addr_is(a, ADDR_INDEX)
                    | addr_is(a, ADDR_DATA) | addr_is(a, ADDR_SECURITY);
    endfunction

    // Status word: complete, access error, protection and verify flags
    function automatic logic [31:0] status_word(input fsmc_regs_t s);
        logic [31:0] w;
        w                = 32'h0000_0000;
        w[ST_COMMAND_COMPLETE_FLAG_BIT]   = s.command_complete_flag;
        w[ST_ACCESS_ERROR_FLAG_BIT] = s.access_error_flag;
        w[ST_PROTECTION_VIOLATION_FLAG_BIT] = s.protection_violation_flag;
        w[ST_MG1_BIT]    = s.mg1;
        w[ST_MG0_BIT]    = s.mg0;
        status_word      = w;
    endfunction

    // Index word: command word index in the low bits
    function automatic logic [31:0] index_word(input fsmc_regs_t s);
        logic [31:0] w;
        w          = 32'h0000_0000;
        w[2:0]     = s.idx;
        index_word = w;
    endfunction

    // Data word: command word at the current index, zero past the last word
    function automatic logic [31:0] data_word(input fsmc_regs_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (s.idx <= IDX_LAST) begin
            w[15:0] = s.ccob[s.idx];
        end
        data_word = w;
    endfunction

    // Security word: backdoor lock, secured state and both read margins
    function automatic logic [31:0] security_word(input fsmc_regs_t s);
        logic [31:0] w;
        w                       = 32'h0000_0000;
        w[SEC_LOCK_BIT]         = s.key_locked;
        w[SEC_SECURED_BIT]      = s.secured;
        w[SEC_PMARGIN_LSB +: 2] = s.pmargin;
        w[SEC_DMARGIN_LSB +: 2] = s.dmargin;
        security_word           = w;
    endfunction

    // Unsecure refused on a wrong index or in a mode without it
    function automatic logic unsecure_refused(input logic [2:0] ix, input logic mode_ok);
        unsecure_refused = (ix != IDX_UNSECURE) || !mode_ok;
    endfunction

    // Backdoor command runs only under the one key-enable code
    function automatic logic backdoor_enabled(input logic [7:0] cfg);
        backdoor_enabled = (cfg[BACKDOOR_KEY_ENABLE_MSB:BACKDOOR_KEY_ENABLE_LSB] == BACKDOOR_KEY_ENABLE_ON);
    endfunction

    // Margin levels that the margin command accepts
    function automatic logic level_valid(input logic [15:0] lvl);
        level_valid = (lvl == LVL_NORMAL) || (lvl == LVL_USER1) || (lvl == LVL_USER0);
    endfunction

    // Block selects that name a real flash block
    function automatic logic block_valid(input logic [1:0] blk);
        block_valid = (blk == BLK_PFLASH) || (blk == BLK_DFLASH);
    endfunction

    // Margin refused on a wrong index, mode, block or level
    function automatic logic margin_refused(input logic [2:0] ix, input logic mode_ok,
                                            input logic [1:0] blk, input logic [15:0] lvl);
        margin_refused = (ix != IDX_MARGIN) || !mode_ok || !block_valid(blk) || !level_valid(lvl);
    endfunction

    // Any verify error, correctable or not, fails the blank check
    function automatic logic verify_bad(input fsmc_verify_t v);
        verify_bad = v.fail | v.uncorr;
    endfunction

    // Supplied key n against stored word at KEY0_GADDR plus n words
    genvar k;
    generate
        for (k = 0; k < KEY_COUNT; k++) begin : g_key
            assign key_eq[k] = (r_q.ccob[k + int'(IDX_KEY0)] == stored_keys_in[k]);
        end
    endgenerate

    // Next-state logic: bus slave and command sequencer
    always_comb begin
        logic        acc;
        logic        wr_done;
        logic        mapped;
        logic        launch;
        logic [7:0]  code;
        logic [1:0]  blk;
        logic [15:0] lvl;
        logic [31:0] rd;
        acc     = 1'b0;
        wr_done = 1'b0;
        mapped  = 1'b0;
        launch  = 1'b0;
        code    = r_q.ccob[0][CODE_MSB:CODE_LSB];
        blk     = r_q.ccob[0][BLK_MSB:BLK_LSB];
        lvl     = r_q.ccob[IDX_MARGIN];
        rd      = 32'h0000_0000;
        r_d     = r_q;

        // APB: one wait state, pready from a flop
        acc     = apb_req_in.psel & apb_req_in.penable;
        mapped  = addr_mapped(apb_req_in.paddr);
        r_d.pready  = acc & ~r_q.pready;
        r_d.pslverr = acc & ~r_q.pready & ~mapped;
        wr_done = acc & r_q.pready & apb_req_in.pwrite & ~r_q.pslverr;

        // Read data captured together with pready
        if (addr_is(apb_req_in.paddr, ADDR_STATUS)) begin
            rd = status_word(r_q);
        end else if (addr_is(apb_req_in.paddr, ADDR_INDEX)) begin
            rd = index_word(r_q);
        end else if (addr_is(apb_req_in.paddr, ADDR_DATA)) begin
            rd = data_word(r_q);
        end else if (addr_is(apb_req_in.paddr, ADDR_SECURITY)) begin
            rd = security_word(r_q);
        end
        r_d.prdata = (acc & ~r_q.pready & ~apb_req_in.pwrite) ? rd : 32'h0000_0000;

        // Register writes, all ignored while a command runs
        if (wr_done && r_q.command_complete_flag) begin
            if (addr_is(apb_req_in.paddr, ADDR_STATUS)) begin
                if (apb_req_in.pwdata[ST_ACCESS_ERROR_FLAG_BIT]) begin
                    r_d.access_error_flag = 1'b0;
                end
                if (apb_req_in.pwdata[ST_PROTECTION_VIOLATION_FLAG_BIT]) begin
                    r_d.protection_violation_flag = 1'b0;
                end
                // Writing one to the complete flag launches unless an error flag stays set; only a started command clears it
                launch = apb_req_in.pwdata[ST_COMMAND_COMPLETE_FLAG_BIT] & ~r_d.access_error_flag & ~r_d.protection_violation_flag;
            end else if (addr_is(apb_req_in.paddr, ADDR_INDEX)) begin
                r_d.idx = apb_req_in.pwdata[2:0];
            end else if (addr_is(apb_req_in.paddr, ADDR_DATA)) begin
                if (r_q.idx <= IDX_LAST) begin
                    r_d.ccob[r_q.idx] = apb_req_in.pwdata[15:0];
                end
            end
        end

        // Command launch; every access error completes at once
        if (launch) begin
            r_d.mg1 = 1'b0;
            r_d.mg0 = 1'b0;
            case (code)
                CMD_UNSECURE: begin
                    if (unsecure_refused(r_q.idx, unsecure_mode_ok_in)) begin
                        r_d.access_error_flag = 1'b1;
                    end else if (protect_any_in) begin
                        r_d.protection_violation_flag = 1'b1;
                    end else begin
                        r_d.command_complete_flag      = 1'b0;
                        r_d.erase_req = 1'b1;
                        r_d.st        = ST_ERASE;
                    end
                end
                CMD_BACKDOOR: begin
                    if (r_q.idx != IDX_BACKDOOR) begin
                        r_d.access_error_flag = 1'b1;
                    end else if (!backdoor_enabled(security_config_in)) begin
                        r_d.access_error_flag = 1'b1;
                    end else if (r_q.key_locked) begin
                        r_d.access_error_flag = 1'b1;
                    end else if (&key_eq) begin
                        r_d.secured = 1'b0;
                        r_d.command_complete_flag    = 1'b0;
                        r_d.st      = ST_FINISH;
                    end else begin
                        r_d.access_error_flag     = 1'b1;
                        r_d.key_locked = 1'b1;
                    end
                end
                CMD_MARGIN: begin
                    if (margin_refused(r_q.idx, margin_mode_ok_in, blk, lvl)) begin
                        r_d.access_error_flag = 1'b1;
                    end else begin
                        r_d.dmargin = lvl[1:0];
                        if (blk == BLK_PFLASH) begin
                            r_d.pmargin = lvl[1:0];
                        end
                        r_d.command_complete_flag = 1'b0;
                        r_d.st   = ST_FINISH;
                    end
                end
                default: begin
                    r_d.access_error_flag = 1'b1;
                end
            endcase
        end

        // Sequencer
        case (r_q.st)
            ST_IDLE: begin
            end
            ST_ERASE: begin
                if (verify_in.done) begin
                    r_d.erase_req = 1'b0;
                    r_d.mg1       = verify_bad(verify_in);
                    r_d.mg0       = verify_in.uncorr;
                    if (!verify_bad(verify_in)) begin
                        r_d.secured = 1'b0;
                    end
                    r_d.command_complete_flag = 1'b1;
                    r_d.st   = ST_IDLE;
                end
            end
            ST_FINISH: begin
                r_d.command_complete_flag = 1'b1;
                r_d.st   = ST_IDLE;
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            r_q            <= '0;
            r_q.st         <= ST_IDLE;
            r_q.command_complete_flag       <= 1'b1;
            r_q.secured    <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from the state register
    assign prdata_out                = r_q.prdata;
    assign pready_out                = r_q.pready;
    assign pslverr_out               = r_q.pslverr;
    assign erase_req_out             = r_q.erase_req;
    assign secured_out               = r_q.secured;
    assign command_complete_flag_out = r_q.command_complete_flag;
    assign pflash_read_margin_out    = r_q.pmargin;
    assign dflash_read_margin_out    = r_q.dmargin;

endmodule

`default_nettype wire

// file: rtl/fsmc_pkg.sv
package fsmc_pkg;

    // Register byte addresses on the APB slave
    localparam logic [7:0]  ADDR_STATUS   = 8'h00;
    localparam logic [7:0]  ADDR_INDEX    = 8'h04;
    localparam logic [7:0]  ADDR_DATA     = 8'h08;
    localparam logic [7:0]  ADDR_SECURITY = 8'h0C;

    // Status register bit positions (flash_status)
    localparam int          ST_COMMAND_COMPLETE_FLAG_BIT   = 7;
    localparam int          ST_ACCESS_ERROR_FLAG_BIT = 5;
    localparam int          ST_PROTECTION_VIOLATION_FLAG_BIT = 4;
    localparam int          ST_MG1_BIT    = 1;
    localparam int          ST_MG0_BIT    = 0;

    // Security register bit positions
    localparam int          SEC_LOCK_BIT  = 5;
    localparam int          SEC_SECURED_BIT = 4;
    localparam int          SEC_PMARGIN_LSB = 2;
    localparam int          SEC_DMARGIN_LSB = 0;

    // Command object geometry
    localparam int          CMD_WORDS     = 6;
    localparam logic [2:0]  IDX_LAST      = 3'h5;
    localparam int          CODE_MSB      = 15;
    localparam int          CODE_LSB      = 8;
    localparam int          BLK_MSB       = 1;
    localparam int          BLK_LSB       = 0;

    // Command codes and the index expected at launch
    localparam logic [7:0]  CMD_UNSECURE  = 8'h0B;
    localparam logic [7:0]  CMD_BACKDOOR  = 8'h0C;
    localparam logic [7:0]  CMD_MARGIN    = 8'h0D;
    localparam logic [2:0]  IDX_UNSECURE  = 3'h0;
    localparam logic [2:0]  IDX_BACKDOOR  = 3'h4;
    localparam logic [2:0]  IDX_MARGIN    = 3'h1;
    localparam logic [2:0]  IDX_KEY0      = 3'h1;
    localparam int          KEY_COUNT     = 4;

    // Stored comparison key 0 global address; later keys follow word by word
    localparam logic [17:0] KEY0_GADDR    = 18'h3FF00;

    // Backdoor key enable field in security_config
    localparam int          BACKDOOR_KEY_ENABLE_MSB     = 7;
    localparam int          BACKDOOR_KEY_ENABLE_LSB     = 6;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_ON      = 2'h2;

    // Margin levels and block selects (global address 17:16)
    localparam logic [15:0] LVL_NORMAL    = 16'h0000;
    localparam logic [15:0] LVL_USER1     = 16'h0001;
    localparam logic [15:0] LVL_USER0     = 16'h0002;
    localparam logic [1:0]  BLK_PFLASH    = 2'h3;
    localparam logic [1:0]  BLK_DFLASH    = 2'h0;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_FINISH
    } fsmc_state_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } fsmc_apb_req_t;

    // Verify result from the array after a mass erase
    typedef struct packed {
        logic done;
        logic fail;
        logic uncorr;
    } fsmc_verify_t;

    // Whole state of the sequencer
    typedef struct packed {
        fsmc_state_t                 st;
        logic [CMD_WORDS-1:0][15:0]  ccob;
        logic [2:0]                  idx;
        logic                        command_complete_flag;
        logic                        access_error_flag;
        logic                        protection_violation_flag;
        logic                        mg1;
        logic                        mg0;
        logic                        secured;
        logic                        key_locked;
        logic [1:0]                  pmargin;
        logic [1:0]                  dmargin;
        logic                        erase_req;
        logic                        pready;
        logic                        pslverr;
        logic [31:0]                 prdata;
    } fsmc_regs_t;

endpackage

// file: bench/fsmc_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_sequencer_sva
    import fsmc_pkg::*;
(
    // Clock and reset
    input wire logic         ref_clk_in,
    input wire logic         resetn_in,
    // Observed ports
    input wire logic         erase_req_out,
    input wire fsmc_verify_t verify_in,
    input wire logic         protect_any_in,
    input wire logic         unsecure_mode_ok_in,
    input wire logic         secured_out,
    input wire logic         command_complete_flag_out,
    input wire logic [1:0]   pflash_read_margin_out,
    input wire logic [1:0]   dflash_read_margin_out
);
    // All checks share the one clock
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // Erase sequence
    a_erase_start: assert property ($rose(erase_req_out) |-> $fell(command_complete_flag_out))
        else $error("erase began without a launch");
    a_erase_busy: assert property (erase_req_out |-> !command_complete_flag_out)
        else $error("complete flag high during erase");
    a_erase_end: assert property (erase_req_out && verify_in.done |=> !erase_req_out && command_complete_flag_out)
        else $error("erase did not end after verify");
    a_fail_keeps: assert property (erase_req_out && verify_in.done && (verify_in.fail || verify_in.uncorr)
        |=> $stable(secured_out)) else $error("security changed after failed verify");
    a_pass_frees: assert property (erase_req_out && verify_in.done && !verify_in.fail && !verify_in.uncorr
        |=> !secured_out) else $error("security kept after clean verify");
    // Erase refused on protection or mode
    a_protect_halt: assert property (protect_any_in && !erase_req_out |=> !erase_req_out)
        else $error("erase started while protected");
    a_mode_halt: assert property (!unsecure_mode_ok_in && !erase_req_out |=> !erase_req_out)
        else $error("erase started in a mode without it");
    // Margin levels and security
    a_margin_cmd: assert property ($past(resetn_in) && ($changed(pflash_read_margin_out) ||
        $changed(dflash_read_margin_out)) |-> !command_complete_flag_out || !$past(command_complete_flag_out))
        else $error("margin changed outside a command");
    a_margin_legal: assert property (pflash_read_margin_out != 2'h3 && dflash_read_margin_out != 2'h3)
        else $error("illegal margin level");
    a_sec_no_rise: assert property ($rose(secured_out) |-> !$past(resetn_in))
        else $error("security set again without reset");
    // Main scenarios
    c_pass: cover property (erase_req_out && verify_in.done && !verify_in.fail && !verify_in.uncorr);
    c_fail: cover property (erase_req_out && verify_in.done && verify_in.fail);
    c_margin: cover property ($changed(pflash_read_margin_out));
endmodule
bind fsmc_sequencer fsmc_sequencer_sva i_fsmc_sequencer_sva (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .erase_req_out(erase_req_out), .verify_in(verify_in), .protect_any_in(protect_any_in),
    .unsecure_mode_ok_in(unsecure_mode_ok_in), .secured_out(secured_out),
    .command_complete_flag_out(command_complete_flag_out),
    .pflash_read_margin_out(pflash_read_margin_out), .dflash_read_margin_out(dflash_read_margin_out));
`default_nettype wire

// file: bench/fsmc_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module fsmc_sequencer_test
    import fsmc_pkg::*;
;
    logic                       ref_clk_in = 1'b0;
    logic                       resetn_in = 1'b0;
    fsmc_apb_req_t              apb_req = '0;
    fsmc_verify_t               vrf = '0;
    logic                       prot = 1'b0;
    logic                       uns_ok = 1'b1;
    logic                       mrg_ok = 1'b1;
    logic [7:0]                 scfg = 8'h80;
    logic [KEY_COUNT-1:0][15:0] keys = '0;
    logic [31:0]                prd, rd, r;
    logic                       prdy, perr, se, ers, sec, ccf;
    logic [1:0]                 pm, dm;
    logic [7:0]                 xs;
    logic [4:0][15:0]           kw;
    int                         err_count = 0;
    int                         compares = 0;
    int                         cyc = 0;
    int                         seed = 32'hB891;

    // Clock and design
    always #12.5 ref_clk_in = ~ref_clk_in;
    fsmc_sequencer i_fsmc_sequencer (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .apb_req_in(apb_req),
        .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .erase_req_out(ers), .verify_in(vrf),
        .protect_any_in(prot), .unsecure_mode_ok_in(uns_ok), .margin_mode_ok_in(mrg_ok),
        .security_config_in(scfg), .stored_keys_in(keys), .secured_out(sec),
        .command_complete_flag_out(ccf), .pflash_read_margin_out(pm), .dflash_read_margin_out(dm));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk_in);
        apb_req.penable <= 1'b1;
        do @(posedge ref_clk_in); while (prdy !== 1'b1);
        rd = prd;
        se = perr;
        apb_req <= '0;
    endtask

    // Reset for 16 cycles, model back to secured
    task automatic do_reset;
        resetn_in <= 1'b0;
        repeat (16) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        xs = 8'h10;
    endtask

    // Load words, launch, answer the erase, compare with the model
    task automatic cmd(input logic [4:0][15:0] w, input logic [2:0] ix, input logic vf, input logic vu);
        logic [7:0] xst;
        logic       go;
        xst = 8'h80;
        go = 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_INDEX, i);
            apb(1'b1, ADDR_DATA, {16'h0, w[i]});
        end
        apb(1'b1, ADDR_INDEX, {29'h0, ix});
        case (w[0][CODE_MSB:CODE_LSB])
            CMD_UNSECURE: begin
                if (ix != IDX_UNSECURE || !uns_ok) xst[ST_ACCESS_ERROR_FLAG_BIT] = 1'b1;
                else if (prot) xst[ST_PROTECTION_VIOLATION_FLAG_BIT] = 1'b1;
                else go = 1'b1;
            end
            CMD_BACKDOOR: begin
                if (ix != IDX_BACKDOOR || scfg[BACKDOOR_KEY_ENABLE_MSB:BACKDOOR_KEY_ENABLE_LSB] != BACKDOOR_KEY_ENABLE_ON || xs[SEC_LOCK_BIT])
                    xst[ST_ACCESS_ERROR_FLAG_BIT] = 1'b1;
                else if (w[4:1] == keys) xs[SEC_SECURED_BIT] = 1'b0;
                else xs[SEC_LOCK_BIT] = 1'b1;
                if (xs[SEC_LOCK_BIT]) xst[ST_ACCESS_ERROR_FLAG_BIT] = 1'b1;
            end
            CMD_MARGIN: begin
                if (ix != IDX_MARGIN || !mrg_ok || !(w[0][1:0] inside {BLK_PFLASH, BLK_DFLASH}) || w[1] > LVL_USER0)
                    xst[ST_ACCESS_ERROR_FLAG_BIT] = 1'b1;
                else xs[3:0] = (w[0][1:0] == BLK_PFLASH) ? {2{w[1][1:0]}} : {xs[3:2], w[1][1:0]};
            end
            default: xst[ST_ACCESS_ERROR_FLAG_BIT] = 1'b1;
        endcase
        apb(1'b1, ADDR_STATUS, 32'h80);
        if (go) begin
            // Only waiting here, no writes while busy
            while (ers !== 1'b1) @(posedge ref_clk_in);
            repeat (1 + {$random(seed)} % 8) @(posedge ref_clk_in);
            vrf <= '{1'b1, vf, vu};
            @(posedge ref_clk_in);
            vrf <= '0;
            xst[1:0] = {vf | vu, vu};
            if (!(vf | vu)) xs[SEC_SECURED_BIT] = 1'b0;
        end
        apb(1'b0, ADDR_STATUS, 0);
        chk(rd, 32'(xst));
        apb(1'b0, ADDR_SECURITY, 0);
        chk(rd, 32'(xs));
        chk(32'({ccf, sec, pm, dm}), 32'({1'b1, xs[4:0]}));
        apb(1'b1, ADDR_STATUS, 32'h30);
    endtask

    // Hang guard
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            test_done;
        end
    end

    // Main sequence
    initial begin
        keys <= {$random(seed), $random(seed)};
        do_reset;
        apb(1'b0, ADDR_SECURITY, 0);
        chk(rd, 32'h10);
        apb(1'b0, 8'h10, 0);
        chk({rd[30:0], se}, 32'h1);
        cmd({64'h0, 16'h0E00}, 3'h0, 1'b0, 1'b0);
        $display("reset and decode test done");
        kw = {keys, CMD_BACKDOOR, 8'h00};
        prot <= 1'b1;
        scfg <= 8'h40;
        cmd(kw, IDX_BACKDOOR, 1'b0, 1'b0);
        scfg <= 8'h80;
        cmd(kw, 3'h3, 1'b0, 1'b0);
        kw[2] = ~kw[2];
        cmd(kw, IDX_BACKDOOR, 1'b0, 1'b0);
        kw[2] = ~kw[2];
        cmd(kw, IDX_BACKDOOR, 1'b0, 1'b0);
        do_reset;
        cmd(kw, IDX_BACKDOOR, 1'b0, 1'b0);
        prot <= 1'b0;
        $display("backdoor test done");
        do_reset;
        kw = {64'h0, CMD_UNSECURE, 8'h00};
        prot <= 1'b1;
        cmd(kw, IDX_UNSECURE, 1'b0, 1'b0);
        prot <= 1'b0;
        uns_ok <= 1'b0;
        cmd(kw, IDX_UNSECURE, 1'b0, 1'b0);
        uns_ok <= 1'b1;
        cmd(kw, 3'h1, 1'b0, 1'b0);
        for (int i = 3; i >= 0; i--) cmd(kw, IDX_UNSECURE, i[1], i[0]);
        $display("unsecure test done");
        repeat (40) begin
            r = $random(seed);
            mrg_ok <= |r[7:4];
            cmd({48'h0, 14'h0, r[1:0], CMD_MARGIN, 6'h0, r[3:2]}, (|r[10:8]) ? IDX_MARGIN : 3'h2, 1'b0, 1'b0);
        end
        $display("margin test done");
        test_done;
    end
endmodule
`default_nettype wire
